// ---- shared/wcg_pkg.sv ----
/*
 Constants for the wake-up and clock gating block: register map, field layouts,
 reset values, clock selection states and timing counts.
 Assumes a single 10 MHz system clock and an AXI4-Lite master with 32-bit data.
*/
// Functional notes
// RULE1: Per-pin polarity bit, one selects high
// RULE2: Per-pin wake enable, reset enables lower three
// RULE3: Crystal flag bit zero, 32 MHz when set
// RULE4: Fast crystal: only core, DMA, bus fast
// RULE5: Sixteen peripheral bus clocks individually gateable
// RULE6: All peripheral bus clocks enabled after reset
// RULE7: Processor clock stops during sleep automatically
// RULE8: RAM clock off when processor, SPI, radio off
// RULE9: Ring oscillator clocks system during crystal startup
// RULE10: Low-frequency source selectable crystal or ring
// RULE11: Radio allowed only on crystal clock
// RULE12: Pin wakes device only when enabled
// RULE13: Command 0x15 switches fast domain after delay
// RULE14: Command 0x14 returns fast domain to 16 MHz
// RULE15: Reserved bits read zero, ignore writes
package wcg_pkg;
  // Byte addresses
  localparam logic [7:0] WAKE_LEVEL_OFS = 8'h00;
  localparam logic [7:0] WAKE_ENABLE_OFS = 8'h04;
  localparam logic [7:0] XTAL_CFG_OFS = 8'h08;
  localparam logic [7:0] BUS_RATE_OFS = 8'h0c;
  localparam logic [7:0] CLOCK_GATE_OFS = 8'h10;
  localparam logic [7:0] CLOCK_SRC_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam int WAKE_PINS = 5;
  localparam int GATE_BITS = 16;
  localparam logic [4:0] WAKE_LEVEL_RST = 5'h00;
  localparam logic [4:0] WAKE_ENABLE_RST = 5'h07;
  localparam logic XTAL_CFG_RST = 1'b0;
  localparam logic [7:0] BUS_RATE_RST = 8'h00;
  localparam logic [15:0] CLOCK_GATE_RST = 16'hffff;
  // Peripheral gate bit positions
  localparam int GATE_DMA = 0;
  localparam int GATE_RADIO = 1;
  localparam int GATE_RADIO_CLKGEN = 2;
  localparam int GATE_SPI = 8;
  // Clock source register fields
  localparam int SRC_XTAL_READY = 0;
  localparam int SRC_LF_XTAL = 1;
  localparam logic [1:0] CLOCK_SRC_RST = 2'h0;
  // Bus-rate converter commands
  localparam logic [7:0] CMD_FAST = 8'h15;
  localparam logic [7:0] CMD_SLOW = 8'h14;
  localparam int SWITCH_CYCLES = 10;
  localparam logic [3:0] SWITCH_CNT = 4'(SWITCH_CYCLES);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {WCG_RING, WCG_XTAL, WCG_SWITCHING, WCG_FAST} wcg_clk_e;
endpackage : wcg_pkg

// ---- logic/wcg_top.sv ----
/*
 Wake-up configuration and clock gating controller with an AXI4-Lite slave.
 Assumes synchronous wake pins and status inputs; clock enables drive
 external gating cells, the divide-by-two is a one-cycle enable pulse.
*/
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module wcg_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // AXI4-Lite write address
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Wake pins and power state
  input wire logic [4:0] wake_pin,
  input wire logic low_power,
  input wire logic sleep_mode,
  input wire logic xtal_stable,
  output logic wake_request,
  // Clock control
  output logic [15:0] periph_clk_en,
  output logic cpu_clk_en,
  output logic ram_clk_en,
  output logic fast_domain_32,
  output logic half_rate_en,
  output logic hs_from_xtal,
  output logic lf_from_xtal,
  output logic radio_allowed
);
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [4:0] wake_level;
    logic [4:0] wake_enable;
    logic fast_crystal_flag;
    logic [7:0] bus_rate_cmd;
    logic [15:0] gate;
    logic [1:0] clock_src;
    wcg_pkg::wcg_clk_e clk_state;
    logic [3:0] switch_cnt;
    logic half_phase;
    logic wake_request;
  } wcg_state_s;

  wcg_state_s st;
  wcg_state_s next_st;

  function automatic logic [31:0] wcg_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : wcg_merge

  function automatic logic wcg_mapped(input logic [7:0] a);
    return a == wcg_pkg::WAKE_LEVEL_OFS || a == wcg_pkg::WAKE_ENABLE_OFS ||
           a == wcg_pkg::XTAL_CFG_OFS || a == wcg_pkg::BUS_RATE_OFS ||
           a == wcg_pkg::CLOCK_GATE_OFS || a == wcg_pkg::CLOCK_SRC_OFS ||
           a == wcg_pkg::STATUS_OFS;
  endfunction : wcg_mapped

  ////////////////////////////////////////////////////////////////////////////
  logic do_write;
  logic do_read;
  logic [31:0] merged;
  logic [4:0] pin_match;

  assign awready = !st.aw_got && !st.bvalid;
  assign wready = !st.w_got && !st.bvalid;
  assign arready = !st.rvalid;
  assign do_write = st.aw_got && st.w_got && !st.bvalid;
  assign do_read = arvalid && arready;

  always_comb begin
    next_st = st;
    merged = 32'h0000_0000;
    if (awvalid && awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.w_got = 1'b1;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end

    // Clock selection sequencing
    case (st.clk_state)
      wcg_pkg::WCG_RING: begin
        // RULE9: ring until crystal
        if (xtal_stable) begin
          next_st.clk_state = wcg_pkg::WCG_XTAL;
        end
      end
      wcg_pkg::WCG_XTAL: begin
        if (!xtal_stable) begin
          next_st.clk_state = wcg_pkg::WCG_RING;
        end
      end
      wcg_pkg::WCG_SWITCHING: begin
        // RULE13: delayed fast switch
        if (!xtal_stable) begin
          next_st.clk_state = wcg_pkg::WCG_RING;
        end else if (st.switch_cnt == 4'h1) begin
          next_st.clk_state = wcg_pkg::WCG_FAST;
        end
        next_st.switch_cnt = st.switch_cnt - 4'h1;
      end
      wcg_pkg::WCG_FAST: begin
        if (!xtal_stable) begin
          next_st.clk_state = wcg_pkg::WCG_RING;
        end
      end
      default: begin
        next_st.clk_state = wcg_pkg::WCG_RING;
      end
    endcase

    if (do_write) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = wcg_mapped(st.aw_addr) && st.aw_addr != wcg_pkg::STATUS_OFS ?
                      wcg_pkg::RESP_OKAY : wcg_pkg::RESP_SLVERR;
      case (st.aw_addr)
        wcg_pkg::WAKE_LEVEL_OFS: begin
          // RULE1: polarity field
          merged = wcg_merge({27'h0, st.wake_level}, st.w_data, st.w_strb);
          next_st.wake_level = merged[4:0];
        end
        wcg_pkg::WAKE_ENABLE_OFS: begin
          // RULE2: enable field
          merged = wcg_merge({27'h0, st.wake_enable}, st.w_data, st.w_strb);
          next_st.wake_enable = merged[4:0];
        end
        wcg_pkg::XTAL_CFG_OFS: begin
          // RULE3: crystal frequency flag
          if (st.w_strb[0]) begin
            next_st.fast_crystal_flag = st.w_data[0];
          end
        end
        wcg_pkg::BUS_RATE_OFS: begin
          if (st.w_strb[0]) begin
            next_st.bus_rate_cmd = st.w_data[7:0];
            // RULE13: fast only from active
            // A crystal lost in the same cycle wins over any command
            if (st.w_data[7:0] == wcg_pkg::CMD_FAST && st.fast_crystal_flag && xtal_stable &&
                st.clk_state == wcg_pkg::WCG_XTAL) begin
              next_st.clk_state = wcg_pkg::WCG_SWITCHING;
              next_st.switch_cnt = wcg_pkg::SWITCH_CNT;
            end
            // RULE14: back to 16 MHz
            if (st.w_data[7:0] == wcg_pkg::CMD_SLOW && xtal_stable &&
                (st.clk_state == wcg_pkg::WCG_FAST ||
                 st.clk_state == wcg_pkg::WCG_SWITCHING)) begin
              next_st.clk_state = wcg_pkg::WCG_XTAL;
            end
          end
        end
        wcg_pkg::CLOCK_GATE_OFS: begin
          // RULE5: software gates
          merged = wcg_merge({16'h0, st.gate}, st.w_data, st.w_strb);
          next_st.gate = merged[15:0];
        end
        wcg_pkg::CLOCK_SRC_OFS: begin
          // RULE10: low-frequency source select
          if (st.w_strb[0]) begin
            next_st.clock_src = st.w_data[1:0];
          end
        end
        default: begin
        end
      endcase
    end

    if (do_read) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = wcg_mapped(araddr) ? wcg_pkg::RESP_OKAY : wcg_pkg::RESP_SLVERR;
      // RULE15: reserved bits zero
      case (araddr)
        wcg_pkg::WAKE_LEVEL_OFS: next_st.rdata = {27'h0, st.wake_level};
        wcg_pkg::WAKE_ENABLE_OFS: next_st.rdata = {27'h0, st.wake_enable};
        wcg_pkg::XTAL_CFG_OFS: next_st.rdata = {31'h0, st.fast_crystal_flag};
        wcg_pkg::BUS_RATE_OFS: next_st.rdata = {24'h0, st.bus_rate_cmd};
        wcg_pkg::CLOCK_GATE_OFS: next_st.rdata = {16'h0, st.gate};
        wcg_pkg::CLOCK_SRC_OFS: next_st.rdata = {30'h0, st.clock_src};
        wcg_pkg::STATUS_OFS: next_st.rdata = {24'h0, 1'b0, wake_pin, hs_from_xtal,
                                              fast_domain_32};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end

    // RULE4: halved branch enable
    next_st.half_phase = !st.half_phase;

    // RULE12: enabled pins only
    next_st.wake_request = low_power && |(pin_match & st.wake_enable);

    if (reset) begin
      next_st = '0;
      next_st.wake_level = wcg_pkg::WAKE_LEVEL_RST;
      next_st.wake_enable = wcg_pkg::WAKE_ENABLE_RST;
      next_st.fast_crystal_flag = wcg_pkg::XTAL_CFG_RST;
      next_st.bus_rate_cmd = wcg_pkg::BUS_RATE_RST;
      // RULE6: all clocks enabled
      next_st.gate = wcg_pkg::CLOCK_GATE_RST;
      next_st.clock_src = wcg_pkg::CLOCK_SRC_RST;
      next_st.clk_state = wcg_pkg::WCG_RING;
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE1: level compare per pin
  genvar g;
  generate
    for (g = 0; g < wcg_pkg::WAKE_PINS; g++) begin : g_pin
      assign pin_match[g] = wake_pin[g] == st.wake_level[g];
    end
  endgenerate

  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign rvalid = st.rvalid;
  assign rresp = st.rresp;
  assign rdata = st.rdata;
  assign wake_request = st.wake_request;
  assign periph_clk_en = st.gate;
  // RULE7: processor clock off in sleep
  assign cpu_clk_en = !sleep_mode;
  // RULE8: RAM gated when all three off
  assign ram_clk_en = cpu_clk_en || st.gate[wcg_pkg::GATE_SPI] ||
                      st.gate[wcg_pkg::GATE_RADIO];
  assign fast_domain_32 = st.clk_state == wcg_pkg::WCG_FAST;
  // RULE4: non-fast branches tick every other cycle at 32 MHz, every cycle at 16 MHz
  assign half_rate_en = fast_domain_32 ? st.half_phase : 1'b1;
  assign hs_from_xtal = st.clk_state != wcg_pkg::WCG_RING;
  // RULE10: low-frequency source
  assign lf_from_xtal = st.clock_src[wcg_pkg::SRC_LF_XTAL];
  // RULE11: radio on crystal only
  assign radio_allowed = hs_from_xtal && st.gate[wcg_pkg::GATE_RADIO];
endmodule : wcg_top

// ---- dv/wcg_far_side.sv ----
/*
 Far side model: high-speed crystal start-up and the wake pin levels.
 Assumes the bench switches the oscillator and sets pin levels after clock edges.
*/
`timescale 1ns/1ps
module wcg_far_side #(parameter int STARTUP = 20) (
  // Clock
  input wire logic mclk,
  // Bench controls
  input wire logic osc_on,
  input wire logic [4:0] pins_set,
  // Toward the controller
  output logic xtal_stable,
  output logic [4:0] wake_pin
);
  int cnt = 0;
  // Push-pull pads, so the pins always carry a level
  assign wake_pin = pins_set;
  // Stable only after start-up; drops at once when the crystal stops
  always @(posedge mclk) begin
    cnt <= osc_on ? (cnt < STARTUP ? cnt + 1 : cnt) : 0;
  end
  assign xtal_stable = cnt >= STARTUP;
endmodule : wcg_far_side

// ---- dv/wcg_properties.sv ----
/*
 Port checker for the wake and clock gating controller.
 Bound to wcg_top; sees only its ports.
*/
`timescale 1ns/1ps
module wcg_properties (
  // Clock, reset, write bus
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  // Power state and clock outputs
  input wire logic low_power,
  input wire logic sleep_mode,
  input wire logic xtal_stable,
  input wire logic wake_request,
  input wire logic [15:0] periph_clk_en,
  input wire logic cpu_clk_en,
  input wire logic ram_clk_en,
  input wire logic fast_domain_32,
  input wire logic half_rate_en,
  input wire logic hs_from_xtal,
  input wire logic radio_allowed
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic cmd_wr;
  logic [7:0] since_fast;
  assign cmd_wr = awvalid && awready && wvalid && wready && awaddr == 8'h0c;
  // Cycles since the last fast command, saturating
  always_ff @(posedge mclk) begin
    if (reset) since_fast <= 8'hff;
    else if (cmd_wr && wdata[7:0] == 8'h15) since_fast <= 8'h00;
    else if (since_fast != 8'hff) since_fast <= since_fast + 8'h01;
  end
  sequence s_slow_cmd;
    cmd_wr && wdata[7:0] == 8'h14;
  endsequence
  sequence s_fast_run;
    fast_domain_32 ##1 fast_domain_32;
  endsequence
  AST_CPU_SLEEP: assert property (cpu_clk_en == !sleep_mode)
    else $error("cpu clock not following sleep");
  AST_RAM_GATE: assert property (ram_clk_en == (cpu_clk_en | periph_clk_en[8] | periph_clk_en[1]))
    else $error("ram clock gating wrong");
  AST_RADIO_XTAL: assert property (radio_allowed |-> hs_from_xtal)
    else $error("radio allowed on ring clock");
  AST_RING_START: assert property (!xtal_stable |=> !hs_from_xtal)
    else $error("crystal used before stable");
  AST_HALF_RATE: assert property (s_fast_run |-> half_rate_en != $past(half_rate_en))
    else $error("slow branch not divided");
  AST_FULL_RATE: assert property (!fast_domain_32 ##1 !fast_domain_32 |-> half_rate_en)
    else $error("slow branch gated at 16 MHz");
  AST_NO_WAKE: assert property (!low_power |=> !wake_request)
    else $error("wake outside low power");
  AST_GATE_RESET: assert property ($fell(reset) |-> periph_clk_en == 16'hffff)
    else $error("gates not enabled after reset");
  AST_FAST_DELAY: assert property ($rose(fast_domain_32) |-> since_fast inside {[8:13]})
    else $error("fast switch delay wrong");
  AST_SLOW_CMD: assert property (s_slow_cmd |-> ##[1:4] !fast_domain_32)
    else $error("slow command ignored");
endmodule : wcg_properties
bind wcg_top wcg_properties u_props (.mclk, .reset, .awaddr, .awvalid, .awready, .wdata,
  .wvalid, .wready, .low_power, .sleep_mode, .xtal_stable, .wake_request, .periph_clk_en,
  .cpu_clk_en, .ram_clk_en, .fast_domain_32, .half_rate_en, .hs_from_xtal, .radio_allowed);

// ---- dv/wakeup_and_clock_gating_test.sv ----
/*
 Self-checking bench for the wake and clock gating controller.
 Assumes the far side model and the bound port checker.
*/
`timescale 1ns/1ps
module wakeup_and_clock_gating_test;
  logic mclk = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b1, rready = 1'b1, low_power = 1'b0, sleep_mode = 1'b0, osc_on = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hf;
  logic [4:0] pins_set = 5'h00, wake_pin;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] periph_clk_en, rnd = 16'hea04;
  logic awready, wready, bvalid, arready, rvalid, xtal_stable, wake_request, cpu_clk_en;
  logic ram_clk_en, fast_domain_32, half_rate_en, hs_from_xtal, lf_from_xtal, radio_allowed;
  logic [7:0] ad[4] = '{8'h00, 8'h04, 8'h08, 8'h10};
  logic [31:0] rv[4] = '{32'h0, 32'h7, 32'h0, 32'hffff};
  logic [31:0] mk[4] = '{32'h1f, 32'h1f, 32'h1, 32'hffff};
  int errors = 0, compares = 0, n;
  always #50 mclk = ~mclk;
  wcg_top DUT (.mclk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .wake_pin, .low_power, .sleep_mode, .xtal_stable, .wake_request, .periph_clk_en,
    .cpu_clk_en, .ram_clk_en, .fast_domain_32, .half_rate_en, .hs_from_xtal, .lf_from_xtal,
    .radio_allowed);
  wcg_far_side far (.mclk, .osc_on, .pins_set, .xtal_stable, .wake_pin);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic wake_exp(input logic [4:0] en, lvl, pin);
    return |(en & ~(pin ^ lvl));
  endfunction : wake_exp
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string name, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Handshakes are judged at the falling edge, acted on after the rising one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    n = 0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    while (!tb) begin
      @(negedge mclk);
      ta = awvalid && awready; tw = wvalid && wready; tb = bvalid === 1'b1; rs = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (++n > 40) begin errors++; wrap_up(); end
    end
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    logic ta, tr;
    tr = 1'b0;
    n = 0;
    araddr <= a; arvalid <= 1'b1;
    while (!tr) begin
      @(negedge mclk);
      ta = arvalid && arready; tr = rvalid === 1'b1; rd = rdata; rs = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
      if (++n > 40) begin errors++; wrap_up(); end
    end
  endtask : rd_reg
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      rd_reg(ad[i]); chk("reset_value", rd, rv[i]);
      wr(ad[i], 32'hffffffff); chk("wr_resp", rs, wcg_pkg::RESP_OKAY);
      rd_reg(ad[i]); chk("reserved", rd, mk[i]);
    end
    rd_reg(8'h1c); chk("unmapped_resp", rs, wcg_pkg::RESP_SLVERR);
    chk("unmapped_data", rd, 32'h0);
    wr(8'h18, 32'h1); chk("status_write", rs, wcg_pkg::RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd); sleep_mode <= (i == 7) ? 1'b1 : rnd[3];
      if (i == 7) rnd = 16'h0000;
      wr(8'h10, rnd); @(negedge mclk); chk("gate", periph_clk_en, rnd);
      chk("cpu_clk", cpu_clk_en, !sleep_mode);
      chk("ram_clk", ram_clk_en, !sleep_mode | rnd[8] | rnd[1]);
      @(posedge mclk);
    end
    sleep_mode <= 1'b0; wr(8'h10, 32'hffff);
    for (int i = 0; i < 14; i++) begin
      rnd = lfsr(rnd);
      wr(8'h00, rnd[4:0]); wr(8'h04, rnd[9:5]);
      pins_set <= rnd[14:10]; low_power <= rnd[15];
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk("wake", wake_request, rnd[15] & wake_exp(rnd[9:5], rnd[4:0], rnd[14:10]));
      @(posedge mclk);
    end
    low_power <= 1'b0; osc_on <= 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk("ring_startup", {hs_from_xtal, radio_allowed}, 2'b00);
    repeat (24) @(posedge mclk);
    @(negedge mclk);
    chk("on_crystal", {hs_from_xtal, radio_allowed}, 2'b11);
    @(posedge mclk);
    // Flag was set by the reserved-bit pass; clear it so the command is refused
    wr(8'h08, 32'h0); wr(8'h0c, 32'h15); repeat (14) @(posedge mclk);
    @(negedge mclk);
    chk("flag_clear", fast_domain_32, 1'b0);
    @(posedge mclk);
    wr(8'h08, 32'h1); wr(8'h0c, 32'h15);
    for (n = 0; n < 30 && fast_domain_32 !== 1'b1; n++) @(negedge mclk);
    chk("fast_delay", n inside {[7:12]}, 1'b1);
    if (n >= 30) wrap_up();
    @(posedge mclk);
    rd_reg(8'h0c); chk("bus_rate_cmd", rd, 32'h15);
    rd_reg(8'h18); chk("status", rd, {24'h0, 1'b0, pins_set, 2'b11});
    wr(8'h0c, 32'h14); @(negedge mclk); chk("slow_cmd", fast_domain_32, 1'b0);
    @(posedge mclk);
    wr(8'h14, 32'h2); chk("lf_xtal", lf_from_xtal, 1'b1);
    wr(8'h14, 32'h0); chk("lf_ring", lf_from_xtal, 1'b0);
    osc_on <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("crystal_lost", {hs_from_xtal, radio_allowed}, 2'b00);
    wrap_up();
  end
endmodule : wakeup_and_clock_gating_test
